// ### design/sics_pkg.sv
// Package for the servo input control select block
`default_nettype none
package sics_pkg;
    // Input bit positions within the synchronised contact vector
    localparam int unsigned IN_PROP = 0;
    localparam int unsigned IN_STOP = 1;
    localparam int unsigned IN_CLR = 2;
    localparam int unsigned IN_MODE = 3;
    localparam int unsigned IN_SPD1 = 4;
    localparam int unsigned IN_TLIM = 5;
    localparam int unsigned IN_COUNT = 6;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] CLRCNT_OFS = 8'h08;

    // Control register fields
    localparam int unsigned CTRL_LEVEL_BIT = 0;
    localparam int unsigned CTRL_MODE_LSB = 1;
    localparam int unsigned CTRL_MODE_W = 3;

    // Status register fields
    localparam int unsigned ST_PROP_BIT = 0;
    localparam int unsigned ST_STOP_BIT = 1;
    localparam int unsigned ST_CLR_BIT = 2;
    localparam int unsigned ST_CTRL_LSB = 3;
    localparam int unsigned ST_SPD_LSB = 5;
    localparam int unsigned ST_IN_LSB = 7;

    // Operating mode settings
    typedef enum logic [2:0] {
        SICS_OP_POS = 3'b000,
        SICS_OP_SPD = 3'b001,
        SICS_OP_TRQ = 3'b010,
        SICS_OP_POS_SPD = 3'b011,
        SICS_OP_SPD_TRQ = 3'b100,
        SICS_OP_TRQ_POS = 3'b101
    } sics_op_t;

    // Active control loop
    typedef enum logic [1:0] {
        SICS_CTRL_POS = 2'b00,
        SICS_CTRL_SPD = 2'b01,
        SICS_CTRL_TRQ = 2'b10
    } sics_ctrl_t;

    // Reset values
    localparam logic CTRL_LEVEL_RST = 1'b0;
    localparam sics_op_t CTRL_MODE_RST = SICS_OP_POS;
    localparam logic [IN_COUNT-1:0] IN_RST = 6'h00;
    localparam logic [15:0] CLRCNT_RST = 16'h0000;
endpackage
`default_nettype wire

// ### design/sics_pin_if.sv
// Carrier between the top module and the contact synchroniser
`timescale 1ns/1ps
`default_nettype none
interface sics_pin_if #(parameter int unsigned N = 6);
    logic [N-1:0] raw;
    logic [N-1:0] level;
    modport src (output raw, input level);
    modport snk (input raw, output level);
endinterface
`default_nettype wire

// ### design/sics_sync.sv
// Three-stage contact synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module sics_sync
    import sics_pkg::*;
#(
    parameter int unsigned N = 6
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // Contacts in, filtered levels out
    sics_pin_if.snk pins
);
    logic [N-1:0] s1_q;
    logic [N-1:0] s2_q;
    logic [N-1:0] s3_q;
    logic [N-1:0] lvl_q;

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_bit
            always_ff @(posedge mclk_i) begin
                if (sys_rst_i) begin
                    s1_q[g] <= IN_RST[g];
                    s2_q[g] <= IN_RST[g];
                    s3_q[g] <= IN_RST[g];
                    lvl_q[g] <= IN_RST[g];
                end else begin
                    s1_q[g] <= pins.raw[g];
                    s2_q[g] <= s1_q[g];
                    s3_q[g] <= s2_q[g];
                    // Change counts only once two late stages agree
                    if (s2_q[g] == s3_q[g]) begin
                        lvl_q[g] <= s3_q[g];
                    end
                end
            end

            sequence s_steady_hi;
                pins.raw[g] [*4];
            endsequence
            sequence s_steady_lo;
                !pins.raw[g] [*4];
            endsequence
            a_sync_settle_hi: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
                s_steady_hi |=> lvl_q[g])
                else $error("filtered level not high after steady input");
            a_sync_settle_lo: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
                s_steady_lo |=> !lvl_q[g])
                else $error("filtered level not low after steady input");
        end
    endgenerate

    assign pins.level = lvl_q;
endmodule
`default_nettype wire

// ### design/sics_top.sv
// Servo contact input decoder with APB control and status
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module sics_top
    import sics_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Contact inputs, 1 means shorted to signal common
    input wire logic proportional_hold_input_i,
    input wire logic forced_stop_input_i,
    input wire logic droop_clear_input_i,
    input wire logic mode_change_input_i,
    input wire logic speed_select_low_i,
    input wire logic torque_limit_select_i,
    // Decoded controls
    output logic prop_only_o,
    output logic forced_stop_o,
    output logic servo_enable_o,
    output logic dyn_brake_o,
    output logic droop_clear_o,
    output sics_pkg::sics_ctrl_t ctrl_mode_o,
    output logic [1:0] speed_sel_o,
    output logic torque_limit_en_o
);
    import sics_pkg::*;

    sics_pin_if #(.N(IN_COUNT)) pins ();

    logic [IN_COUNT-1:0] lv;
    logic clr_prev_q;
    logic level_mode_q;
    sics_op_t op_mode_q;
    logic [15:0] clr_cnt_q;
    logic clr_edge;
    sics_ctrl_t ctrl_d;
    logic [1:0] spd_d;
    logic dual_mode;
    logic [31:0] rdata_d;
    logic rerr_d;
    logic apb_write;

    assign pins.raw = {torque_limit_select_i, speed_select_low_i, mode_change_input_i,
                       droop_clear_input_i, forced_stop_input_i, proportional_hold_input_i};

    sics_sync #(.N(IN_COUNT)) u_sync (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .pins(pins.snk)
    );

    assign lv = pins.level;

    // Proportional-only loop and torque limit follow their contacts
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            prop_only_o <= 1'b0;
            torque_limit_en_o <= 1'b0;
        end else begin
            prop_only_o <= lv[IN_PROP];
            torque_limit_en_o <= lv[IN_TLIM];
        end
    end

    // Forced stop; held in stop through reset so the motor never starts unasked
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            forced_stop_o <= 1'b1;
            servo_enable_o <= 1'b0;
            dyn_brake_o <= 1'b1;
        end else if (!lv[IN_STOP]) begin
            forced_stop_o <= 1'b1;
            servo_enable_o <= 1'b0;
            dyn_brake_o <= 1'b1;
        end else if (forced_stop_o) begin
            forced_stop_o <= 1'b0;
            servo_enable_o <= 1'b1;
            dyn_brake_o <= 1'b0;
        end
    end

    // Droop clear: edge mode gives one pulse, level mode follows the contact
    assign clr_edge = lv[IN_CLR] && !clr_prev_q;

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            clr_prev_q <= 1'b0;
            droop_clear_o <= 1'b0;
        end else begin
            clr_prev_q <= lv[IN_CLR];
            if (level_mode_q) begin
                droop_clear_o <= lv[IN_CLR];
            end else begin
                droop_clear_o <= clr_edge;
            end
        end
    end

    // Counts leading edges; the host's minimum width keeps bounce out of it
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            clr_cnt_q <= CLRCNT_RST;
        end else if (clr_edge) begin
            clr_cnt_q <= clr_cnt_q + 16'h0001;
        end
    end

    // Control mode and speed source selection
    assign dual_mode = (op_mode_q == SICS_OP_POS_SPD) || (op_mode_q == SICS_OP_SPD_TRQ)
                       || (op_mode_q == SICS_OP_TRQ_POS);

    always_comb begin
        ctrl_d = SICS_CTRL_POS;
        case (op_mode_q)
            SICS_OP_POS: begin
                ctrl_d = SICS_CTRL_POS;
            end
            SICS_OP_SPD: begin
                ctrl_d = SICS_CTRL_SPD;
            end
            SICS_OP_TRQ: begin
                ctrl_d = SICS_CTRL_TRQ;
            end
            SICS_OP_POS_SPD: begin
                ctrl_d = lv[IN_MODE] ? SICS_CTRL_SPD : SICS_CTRL_POS;
            end
            SICS_OP_SPD_TRQ: begin
                ctrl_d = lv[IN_MODE] ? SICS_CTRL_TRQ : SICS_CTRL_SPD;
            end
            SICS_OP_TRQ_POS: begin
                ctrl_d = lv[IN_MODE] ? SICS_CTRL_POS : SICS_CTRL_TRQ;
            end
            default: begin
                ctrl_d = SICS_CTRL_POS;
            end
        endcase
    end

    // In single modes the mode pin doubles as the upper speed select bit
    always_comb begin
        if (dual_mode) begin
            spd_d = {1'b0, lv[IN_SPD1]};
        end else begin
            spd_d = {lv[IN_MODE], lv[IN_SPD1]};
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            ctrl_mode_o <= SICS_CTRL_POS;
            speed_sel_o <= 2'h0;
        end else begin
            ctrl_mode_o <= ctrl_d;
            speed_sel_o <= spd_d;
        end
    end

    // APB: answer is ready in the first access cycle, no wait states
    assign apb_write = psel_i && penable_i && pready_o && pwrite_i;

    always_comb begin
        rdata_d = 32'h00000000;
        rerr_d = 1'b0;
        case (paddr_i)
            CTRL_OFS: begin
                rdata_d[CTRL_LEVEL_BIT] = level_mode_q;
                rdata_d[CTRL_MODE_LSB +: CTRL_MODE_W] = op_mode_q;
            end
            STATUS_OFS: begin
                rdata_d[ST_PROP_BIT] = prop_only_o;
                rdata_d[ST_STOP_BIT] = forced_stop_o;
                rdata_d[ST_CLR_BIT] = droop_clear_o;
                rdata_d[ST_CTRL_LSB +: 2] = ctrl_mode_o;
                rdata_d[ST_SPD_LSB +: 2] = speed_sel_o;
                rdata_d[ST_IN_LSB +: IN_COUNT] = lv;
            end
            CLRCNT_OFS: begin
                rdata_d[15:0] = clr_cnt_q;
            end
            default: begin
                rerr_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h00000000;
        end else if (psel_i && !penable_i) begin
            pready_o <= 1'b1;
            pslverr_o <= rerr_d;
            prdata_o <= pwrite_i ? 32'h00000000 : rdata_d;
        end else begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h00000000;
        end
    end

    // Unknown mode codes are kept out so the decode never falls to its default
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            level_mode_q <= CTRL_LEVEL_RST;
            op_mode_q <= CTRL_MODE_RST;
        end else if (apb_write && paddr_i == CTRL_OFS) begin
            level_mode_q <= pwdata_i[CTRL_LEVEL_BIT];
            if (pwdata_i[CTRL_MODE_LSB +: CTRL_MODE_W] <= SICS_OP_TRQ_POS) begin
                op_mode_q <= sics_op_t'(pwdata_i[CTRL_MODE_LSB +: CTRL_MODE_W]);
            end
        end
    end

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (sys_rst_i);

    sequence s_clr_rise;
        !lv[IN_CLR] ##1 lv[IN_CLR];
    endsequence

    a_prop_follows: assert property (
        lv[IN_PROP] [*2] |-> ##1 prop_only_o)
        else $error("proportional-only not set while hold input active");
    a_stop_enter: assert property (
        !lv[IN_STOP] |=> forced_stop_o && !servo_enable_o && dyn_brake_o)
        else $error("forced stop not entered on open input");
    a_stop_leave: assert property (
        $fell(forced_stop_o) |-> $past(lv[IN_STOP], 1) && servo_enable_o && !dyn_brake_o)
        else $error("forced stop left without shorted input");
    a_clr_edge_once: assert property (
        !level_mode_q && droop_clear_o |=> !droop_clear_o)
        else $error("edge clear lasted more than one cycle");
    a_clr_edge_hit: assert property (
        s_clr_rise ##0 !level_mode_q |=> droop_clear_o && clr_cnt_q == $past(clr_cnt_q) + 16'h0001)
        else $error("leading edge did not clear and count once");
    a_clr_level_hold: assert property (
        level_mode_q && lv[IN_CLR] ##1 level_mode_q |-> droop_clear_o)
        else $error("level clear dropped while input active");
    a_mode_pos_spd: assert property (
        op_mode_q == SICS_OP_POS_SPD |=>
        ctrl_mode_o == ($past(lv[IN_MODE]) ? SICS_CTRL_SPD : SICS_CTRL_POS))
        else $error("position/speed selection wrong");
    a_mode_spd_trq: assert property (
        op_mode_q == SICS_OP_SPD_TRQ |=>
        ctrl_mode_o == ($past(lv[IN_MODE]) ? SICS_CTRL_TRQ : SICS_CTRL_SPD))
        else $error("speed/torque selection wrong");
    a_mode_trq_pos: assert property (
        op_mode_q == SICS_OP_TRQ_POS |=>
        ctrl_mode_o == ($past(lv[IN_MODE]) ? SICS_CTRL_POS : SICS_CTRL_TRQ))
        else $error("torque/position selection wrong");
    a_speed_shared: assert property (
        dual_mode |=> speed_sel_o == {1'b0, $past(lv[IN_SPD1])})
        else $error("shared pin leaked into speed select");
    a_apb_answer: assert property (
        psel_i && !penable_i |=> pready_o)
        else $error("APB access phase not ready");
    a_prop_release: assert property (
        !lv[IN_PROP] [*2] |-> ##1 !prop_only_o)
        else $error("proportional-only kept after hold input released");
    a_stop_outputs: assert property (
        servo_enable_o == !forced_stop_o && dyn_brake_o == forced_stop_o)
        else $error("servo enable or brake disagrees with forced stop");
    a_stop_hold: assert property (
        forced_stop_o && !lv[IN_STOP] |=> forced_stop_o)
        else $error("forced stop left while input still open");
    a_clr_level_drop: assert property (
        level_mode_q && !lv[IN_CLR] ##1 level_mode_q |-> !droop_clear_o)
        else $error("level clear stood after input released");
    a_apb_pulse: assert property (
        pready_o |=> !pready_o)
        else $error("APB ready stood longer than one cycle");
    a_clr_count_idle: assert property (
        !clr_edge |=> clr_cnt_q == $past(clr_cnt_q))
        else $error("clear count moved without a leading edge");
endmodule
`default_nettype wire

// ### tb/sics_host_model.sv
// Host controller model that drives the six contact inputs
`timescale 1ns/1ps
`default_nettype none
module sics_host_model
    import sics_pkg::*;
#(
    parameter int unsigned CLR_HOLD = 16
) (
    // Clock
    input wire logic mclk_i,
    // Requested contact states and lock request
    input wire logic [IN_COUNT-1:0] want_i,
    input wire logic lock_i,
    // Contacts, 1 means shorted
    output logic [IN_COUNT-1:0] pin_o
);
    // The long minimum clear hold is shortened to CLR_HOLD cycles to keep runs short
    int unsigned hold = 0;
    always @(posedge mclk_i) begin
        pin_o <= want_i;
        if (hold != 0) begin
            hold <= hold - 1;
        end
        if (lock_i) begin
            pin_o[IN_PROP] <= 1'b1;
            pin_o[IN_TLIM] <= 1'b1;
        end
        if (want_i[IN_CLR] && !pin_o[IN_CLR]) begin
            hold <= CLR_HOLD - 1;
        end else if (pin_o[IN_CLR] && hold != 0) begin
            pin_o[IN_CLR] <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ### tb/servo_input_control_select_test.sv
// Self-checking bench for the servo contact input decoder
`timescale 1ns/1ps
`default_nettype none
module servo_input_control_select_test;
    import sics_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [IN_COUNT-1:0] want = '0;
    logic lock = 1'b0;
    logic [IN_COUNT-1:0] pin;
    logic [31:0] prdata;
    logic pready, pslverr, prop_only, fstop, srv_en, brake, dclr, tlim_en;
    sics_ctrl_t ctrl_mode;
    sics_ctrl_t em;
    logic [1:0] spd_sel;
    logic [1:0] es;
    logic [31:0] rd;
    logic err;
    int fail_count = 0;
    int checks = 0;
    int cyc = 0;
    int clr_hi = 0;
    int s = 0;

    always #12.5 mclk = ~mclk;

    sics_host_model #(.CLR_HOLD(16)) i_host (.mclk_i(mclk), .want_i(want), .lock_i(lock),
        .pin_o(pin));

    sics_top i_sics_top (.mclk_i(mclk), .sys_rst_i(rst), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .proportional_hold_input_i(pin[IN_PROP]),
        .forced_stop_input_i(pin[IN_STOP]), .droop_clear_input_i(pin[IN_CLR]),
        .mode_change_input_i(pin[IN_MODE]), .speed_select_low_i(pin[IN_SPD1]),
        .torque_limit_select_i(pin[IN_TLIM]), .prop_only_o(prop_only), .forced_stop_o(fstop),
        .servo_enable_o(srv_en), .dyn_brake_o(brake), .droop_clear_o(dclr),
        .ctrl_mode_o(ctrl_mode), .speed_sel_o(spd_sel), .torque_limit_en_o(tlim_en));

    task report_and_stop;
        $display("checks=%0d mismatches=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Cuts a hang short and counts clear pulse cycles
    always @(posedge mclk) begin
        cyc++;
        if (dclr === 1'b1) begin
            clr_hi++;
        end
        if (cyc == 20000) begin
            fail_count++;
            report_and_stop();
        end
    end

    task cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task step(input int k);
        repeat (k) @(posedge mclk);
    endtask

    // Entered just after a rising edge; no wait-state count is assumed
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    task rd_cmp(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
        apb(1'b0, a, 32'h0);
        checks++;
        if (rd !== exp || err !== exp_err) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h/%h exp=%h/%h", $time, rd, err, exp, exp_err);
        end
    endtask

    function automatic sics_ctrl_t exp_mode(input int op, input int mode_change_input);
        case (op)
            0: return SICS_CTRL_POS;
            1: return SICS_CTRL_SPD;
            2: return SICS_CTRL_TRQ;
            3: return mode_change_input ? SICS_CTRL_SPD : SICS_CTRL_POS;
            4: return mode_change_input ? SICS_CTRL_TRQ : SICS_CTRL_SPD;
            default: return mode_change_input ? SICS_CTRL_POS : SICS_CTRL_TRQ;
        endcase
    endfunction

    initial begin
        void'($urandom(32'hC2CF0C94));
        step(8);
        rst <= 1'b0;
        step(1);
        cmp({28'h0, fstop, srv_en, brake, dclr}, 32'hA);
        rd_cmp(CTRL_OFS, 32'h0, 1'b0);
        rd_cmp(CLRCNT_OFS, 32'h0, 1'b0);
        $display("test reset done");
        want[IN_STOP] <= 1'b1;
        step(8);
        cmp({29'h0, fstop, srv_en, brake}, 32'h2);
        want[IN_STOP] <= 1'b0;
        step(8);
        cmp({29'h0, fstop, srv_en, brake}, 32'h5);
        want[IN_STOP] <= 1'b1;
        step(8);
        cmp({29'h0, fstop, srv_en, brake}, 32'h2);
        $display("test forced stop done");
        lock <= 1'b1;
        step(8);
        cmp({30'h0, prop_only, tlim_en}, 32'h3);
        lock <= 1'b0;
        want[IN_TLIM] <= 1'b1;
        step(8);
        cmp({30'h0, prop_only, tlim_en}, 32'h1);
        want[IN_TLIM] <= 1'b0;
        $display("test proportional hold done");
        for (int op = 0; op < 6; op++) begin
            apb(1'b1, CTRL_OFS, 32'(op) << 1);
            for (int mode_change_input = 0; mode_change_input < 2; mode_change_input++) begin
                s = $urandom % 2;
                want[IN_MODE] <= mode_change_input[0];
                want[IN_SPD1] <= s[0];
                step(8);
                em = exp_mode(op, mode_change_input);
                es = (op < 3) ? {mode_change_input[0], s[0]} : {1'b0, s[0]};
                cmp({30'h0, ctrl_mode}, {30'h0, em});
                cmp({30'h0, spd_sel}, {30'h0, es});
                rd_cmp(STATUS_OFS, {20'h0, s[0], mode_change_input[0], 3'b010, es, em, 3'b000}, 1'b0);
            end
        end
        $display("test control modes done");
        // Edge mode: one pulse per leading edge, however long the contact is held
        for (int k = 0; k < 2; k++) begin
            clr_hi = 0;
            want[IN_CLR] <= 1'b1;
            step(k ? 30 : 4);
            want[IN_CLR] <= 1'b0;
            step(40);
            cmp(clr_hi, 32'd1);
        end
        rd_cmp(CLRCNT_OFS, 32'h2, 1'b0);
        $display("test edge clear done");
        apb(1'b1, CTRL_OFS, 32'hD);
        rd_cmp(CTRL_OFS, 32'hB, 1'b0);
        apb(1'b1, STATUS_OFS, 32'hFFFFFFFF);
        cmp({31'h0, err}, 32'h0);
        apb(1'b1, 8'h0C, 32'h1);
        cmp({31'h0, err}, 32'h1);
        rd_cmp(8'h0C, 32'h0, 1'b1);
        $display("test register refusals done");
        // Level mode: clear stands as long as the stretched contact does
        for (int k = 0; k < 2; k++) begin
            clr_hi = 0;
            want[IN_CLR] <= 1'b1;
            step(k ? 30 : 4);
            want[IN_CLR] <= 1'b0;
            step(40);
            cmp(clr_hi, k ? 32'd30 : 32'd16);
        end
        $display("test level clear done");
        // Reset in mid-run: stop is forced again and the registers return to reset
        rst <= 1'b1;
        step(2);
        rst <= 1'b0;
        step(1);
        cmp({28'h0, fstop, srv_en, brake, dclr}, 32'hA);
        rd_cmp(CTRL_OFS, 32'h0, 1'b0);
        rd_cmp(CLRCNT_OFS, 32'h0, 1'b0);
        step(8);
        cmp({29'h0, fstop, srv_en, brake}, 32'h2);
        $display("test second reset done");
        report_and_stop();
    end
endmodule
`default_nettype wire
